// *** src/vpp_pkg.sv ***
`default_nettype none
package vpp_pkg;
  // control word bit positions
  localparam int CTL_MODE_BIT  = 0;
  localparam int CTL_SYNC_BIT  = 5;
  localparam int CTL_PED_BIT   = 12;
  localparam int CTL_BPP_LO    = 17;
  localparam int CTL_BPP_HI    = 18;
  localparam int CTL_W         = 24;
  // boot location bit that selects the multiplied clock
  localparam int BOOT_PLL_BIT  = 5;
  localparam int BOOT_W        = 6;
  // register addresses on the host bus
  localparam logic [3:0] ADDR_CTL      = 4'h0;
  localparam logic [3:0] ADDR_MASK     = 4'h1;
  localparam logic [3:0] ADDR_BOOT     = 4'h2;
  localparam logic [3:0] ADDR_PAL_IDX  = 4'h3;
  localparam logic [3:0] ADDR_PAL_DATA = 4'h4;
  localparam logic [3:0] ADDR_GAM_IDX  = 4'h5;
  localparam logic [3:0] ADDR_GAM_DATA = 4'h6;
  // reset values
  localparam logic [CTL_W-1:0] CTL_RESET  = 24'h000000;
  localparam logic [7:0]       MASK_RESET = 8'hFF;
  // level components in output units
  localparam logic [8:0] BLACK_PED_UNITS = 9'h014;
  localparam logic [8:0] SYNC_PED_UNITS  = 9'h06C;
  localparam logic [1:0] BPP8_CODE = 2'h3;
  localparam int QUARTER_DIV = 4;
  localparam int GROUP_BITS  = 32;

  typedef enum logic [1:0] {
    VPP_BPP1_type_e = 2'h0,
    VPP_BPP2_type_e = 2'h1,
    VPP_BPP4_type_e = 2'h2,
    VPP_BPP8_type_e = 2'h3
  } vpp_bpp_type;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } vpp_rgb_type;

  typedef struct packed {
    logic [8:0] red;
    logic [8:0] green;
    logic [8:0] blue;
  } vpp_level_type;
endpackage
`default_nettype wire

// *** src/vpp_video_pixel_input_port.sv ***
`default_nettype none
module vpp_video_pixel_input_port (
  // clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  srst_in,
  // dot enables from both video clock sources; the module selects one
  input  wire logic                  pll_dot_en_in,
  input  wire logic                  direct_dot_en_in,
  // timing generator
  input  wire logic                  active_in,
  input  wire logic                  sync_n_in,
  // pixel lanes
  input  wire logic [7:0]            pixel_lane_a_in,
  input  wire logic [7:0]            pixel_lane_b_in,
  input  wire logic [7:0]            pixel_lane_c_in,
  input  wire logic [7:0]            pixel_lane_d_in,
  // host register port
  input  wire logic                  host_wr_in,
  input  wire logic                  host_rd_in,
  input  wire logic [3:0]            host_addr_in,
  input  wire logic [23:0]           host_addr_data_bus_in,
  output logic      [23:0]           host_rdata_out,
  output logic                       host_rvalid_out,
  // clocks to the video memory
  output logic                       gated_group_clock_out,
  output logic                       free_quarter_dot_clock_out,
  // output level
  output vpp_pkg::vpp_level_type     output_level_units_out
);
  logic [vpp_pkg::CTL_W-1:0]  ctl_q, ctl_d;
  logic [7:0]                 mask_q, mask_d;
  logic [vpp_pkg::BOOT_W-1:0] boot_q, boot_d;
  logic                       boot_open_q, boot_open_d;
  logic [7:0]                 pidx_q, pidx_d, gidx_q, gidx_d;
  logic [23:0]                rdata_q, rdata_d;
  logic                       rvalid_q, rvalid_d;
  vpp_pkg::vpp_rgb_type       palette [256];
  logic [7:0]                 gam_r [256];
  logic [7:0]                 gam_g [256];
  logic [7:0]                 gam_b [256];

  // video pins from outside pass two flops first; the host bus does not
  logic [31:0] lanes_s1_q, lanes_s2_q;
  logic [3:0]  ctl_s1_q, ctl_s2_q;
  logic        act_s, sync_s, pll_s, dir_s;
  always_ff @(posedge clk_in) begin
    lanes_s1_q <= {pixel_lane_d_in, pixel_lane_c_in,
                   pixel_lane_b_in, pixel_lane_a_in};
    lanes_s2_q <= lanes_s1_q;
    ctl_s1_q   <= {active_in, sync_n_in, pll_dot_en_in, direct_dot_en_in};
    ctl_s2_q   <= ctl_s1_q;
  end
  assign {act_s, sync_s, pll_s, dir_s} = ctl_s2_q;

  logic direct_mode, use_pll, dot_en;
  vpp_pkg::vpp_bpp_type bpp;
  assign direct_mode = ctl_q[vpp_pkg::CTL_MODE_BIT];
  assign bpp = vpp_pkg::vpp_bpp_type'(
               ctl_q[vpp_pkg::CTL_BPP_HI:vpp_pkg::CTL_BPP_LO]);
  // the multiplied clock is only ever used in pseudo mode
  assign use_pll = boot_q[vpp_pkg::BOOT_PLL_BIT] & ~direct_mode;
  assign dot_en  = use_pll ? pll_s : dir_s;

  // pixels per group = 32 / bpp
  function automatic logic [5:0] group_len(input vpp_pkg::vpp_bpp_type b);
    unique case (b)
      vpp_pkg::VPP_BPP1_type_e: group_len = 6'h20;
      vpp_pkg::VPP_BPP2_type_e: group_len = 6'h10;
      vpp_pkg::VPP_BPP4_type_e: group_len = 6'h08;
      vpp_pkg::VPP_BPP8_type_e: group_len = 6'h04;
    endcase
  endfunction

  // pick pixel n of the word, low bits first; a right shift places it at bit 0
  function automatic logic [7:0] pick(input logic [31:0] w,
                                      input logic [4:0] n,
                                      input vpp_pkg::vpp_bpp_type b);
    logic [31:0] sh;
    sh = 32'h0;
    unique case (b)
      vpp_pkg::VPP_BPP1_type_e: begin
        sh = w >> n;
        pick = {7'h00, sh[0]};
      end
      vpp_pkg::VPP_BPP2_type_e: begin
        sh = w >> {n[3:0], 1'b0};
        pick = {6'h00, sh[1:0]};
      end
      vpp_pkg::VPP_BPP4_type_e: begin
        sh = w >> {n[2:0], 2'h0};
        pick = {4'h0, sh[3:0]};
      end
      vpp_pkg::VPP_BPP8_type_e: begin
        sh = w >> {n[1:0], 3'h0};
        pick = sh[7:0];
      end
    endcase
  endfunction

  function automatic logic [8:0] add_lvl(input logic [7:0] c,
                                         input logic ped,
                                         input logic syn);
    add_lvl = {1'b0, c} + (ped ? vpp_pkg::BLACK_PED_UNITS : 9'h000)
                        + (syn ? vpp_pkg::SYNC_PED_UNITS : 9'h000);
  endfunction

  // video pipeline state
  logic [31:0] word_q, word_d;
  logic [5:0]  pix_q, pix_d;
  logic [1:0]  qdiv_q, qdiv_d;
  logic        qclk_q, qclk_d;
  logic        gclk_q, gclk_d;
  logic [7:0]  pix_addr_q, pix_addr_d;
  vpp_pkg::vpp_rgb_type direct_q, direct_d;
  vpp_pkg::vpp_level_type lvl_q, lvl_d;
  logic        act_p_q, sync_p_q;
  logic [7:0]  sel;
  vpp_pkg::vpp_rgb_type colour;

  always_comb begin
    word_d   = word_q;
    pix_d    = pix_q;
    qdiv_d   = qdiv_q;
    qclk_d   = qclk_q;
    gclk_d   = 1'b1;
    direct_d = direct_q;
    sel      = pick(word_q, pix_q[4:0], bpp);
    // the pixel mask register gates the palette address the same way at every depth
    pix_addr_d = sel & mask_q;
    if (dot_en) begin
      qdiv_d = qdiv_q + 2'h1;
      if (qdiv_q == 2'(vpp_pkg::QUARTER_DIV / 2 - 1))
        qclk_d = 1'b0;
      if (qdiv_q == 2'(vpp_pkg::QUARTER_DIV - 1))
        qclk_d = 1'b1;
      if (direct_mode) begin
        direct_d = {lanes_s2_q[7:0], lanes_s2_q[15:8],
                    lanes_s2_q[23:16]};
      end else if (act_s) begin
        if (pix_q >= group_len(bpp) - 6'h01) begin
          // group clock low for one clk_in cycle: a falling edge per group
          pix_d  = 6'h00;
          word_d = lanes_s2_q;
          gclk_d = 1'b0;
        end else begin
          pix_d = pix_q + 6'h01;
        end
      end
    end
  end

  assign colour = direct_mode ?
                  {gam_r[direct_q.red], gam_g[direct_q.green],
                   gam_b[direct_q.blue]} :
                  palette[pix_addr_q];

  always_comb begin
    lvl_d = lvl_q;
    if (dot_en) begin
      // pedestal only while active; sync level drops out at the sync tip
      lvl_d.red   = add_lvl(act_p_q ? colour.red : 8'h00,
                            ctl_q[vpp_pkg::CTL_PED_BIT] & act_p_q,
                            ctl_q[vpp_pkg::CTL_SYNC_BIT] & sync_p_q);
      lvl_d.green = add_lvl(act_p_q ? colour.green : 8'h00,
                            ctl_q[vpp_pkg::CTL_PED_BIT] & act_p_q,
                            ctl_q[vpp_pkg::CTL_SYNC_BIT] & sync_p_q);
      lvl_d.blue  = add_lvl(act_p_q ? colour.blue : 8'h00,
                            ctl_q[vpp_pkg::CTL_PED_BIT] & act_p_q,
                            ctl_q[vpp_pkg::CTL_SYNC_BIT] & sync_p_q);
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      word_q     <= 32'h00000000;
      pix_q      <= 6'h00;
      qdiv_q     <= 2'h0;
      qclk_q     <= 1'b1;
      gclk_q     <= 1'b1;
      pix_addr_q <= 8'h00;
      direct_q   <= 24'h000000;
      lvl_q      <= 27'h0000000;
      act_p_q    <= 1'b0;
      sync_p_q   <= 1'b1;
    end else begin
      word_q     <= word_d;
      pix_q      <= pix_d;
      qdiv_q     <= qdiv_d;
      qclk_q     <= qclk_d;
      gclk_q     <= gclk_d;
      pix_addr_q <= pix_addr_d;
      direct_q   <= direct_d;
      lvl_q      <= lvl_d;
      if (dot_en) begin
        act_p_q  <= act_s;
        sync_p_q <= sync_s;
      end
    end
  end

  // host registers; depth must stay fixed while video runs
  always_comb begin
    ctl_d       = ctl_q;
    mask_d      = mask_q;
    boot_d      = boot_q;
    boot_open_d = boot_open_q;
    pidx_d      = pidx_q;
    gidx_d      = gidx_q;
    rdata_d     = rdata_q;
    rvalid_d    = host_rd_in;
    if (host_wr_in) begin
      unique case (host_addr_in)
        vpp_pkg::ADDR_CTL:      ctl_d  = host_addr_data_bus_in;
        vpp_pkg::ADDR_MASK:     mask_d = host_addr_data_bus_in[7:0];
        vpp_pkg::ADDR_BOOT: begin
          // boot location takes one write per reset
          if (boot_open_q) begin
            boot_d      = host_addr_data_bus_in[vpp_pkg::BOOT_W-1:0];
            boot_open_d = 1'b0;
          end
        end
        vpp_pkg::ADDR_PAL_IDX:  pidx_d = host_addr_data_bus_in[7:0];
        vpp_pkg::ADDR_GAM_IDX:  gidx_d = host_addr_data_bus_in[7:0];
        default: ;
      endcase
    end
    if (host_rd_in) begin
      unique case (host_addr_in)
        vpp_pkg::ADDR_CTL:      rdata_d = ctl_q;
        vpp_pkg::ADDR_MASK:     rdata_d = {16'h0000, mask_q};
        vpp_pkg::ADDR_BOOT:     rdata_d = {18'h00000, boot_q};
        vpp_pkg::ADDR_PAL_IDX:  rdata_d = {16'h0000, pidx_q};
        vpp_pkg::ADDR_PAL_DATA: rdata_d = palette[pidx_q];
        vpp_pkg::ADDR_GAM_IDX:  rdata_d = {16'h0000, gidx_q};
        vpp_pkg::ADDR_GAM_DATA: rdata_d = {gam_r[gidx_q], gam_g[gidx_q],
                                           gam_b[gidx_q]};
        default:                rdata_d = 24'h000000;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ctl_q       <= vpp_pkg::CTL_RESET;
      mask_q      <= vpp_pkg::MASK_RESET;
      boot_q      <= 6'h00;
      boot_open_q <= 1'b1;
      pidx_q      <= 8'h00;
      gidx_q      <= 8'h00;
      rdata_q     <= 24'h000000;
      rvalid_q    <= 1'b0;
    end else begin
      ctl_q       <= ctl_d;
      mask_q      <= mask_d;
      boot_q      <= boot_d;
      boot_open_q <= boot_open_d;
      pidx_q      <= pidx_d;
      gidx_q      <= gidx_d;
      rdata_q     <= rdata_d;
      rvalid_q    <= rvalid_d;
    end
  end

  // tables have no reset: contents are undefined until loaded
  always_ff @(posedge clk_in) begin
    if (host_wr_in && host_addr_in == vpp_pkg::ADDR_PAL_DATA)
      palette[pidx_q] <= host_addr_data_bus_in;
    if (host_wr_in && host_addr_in == vpp_pkg::ADDR_GAM_DATA) begin
      gam_r[gidx_q] <= host_addr_data_bus_in[23:16];
      gam_g[gidx_q] <= host_addr_data_bus_in[15:8];
      gam_b[gidx_q] <= host_addr_data_bus_in[7:0];
    end
  end

  assign host_rdata_out             = rdata_q;
  assign host_rvalid_out            = rvalid_q;
  assign gated_group_clock_out      = gclk_q;
  assign free_quarter_dot_clock_out = qclk_q;
  assign output_level_units_out     = lvl_q;
endmodule
`default_nettype wire

// *** bench/vpp_assertions.sv ***
`default_nettype none
module vpp_assertions (
  input wire logic                   clk_in,
  input wire logic                   srst_in,
  input wire logic                   active_in,
  input wire logic                   sync_n_in,
  input wire logic                   host_wr_in,
  input wire logic                   host_rd_in,
  input wire logic [3:0]             host_addr_in,
  input wire logic [23:0]            host_addr_data_bus_in,
  input wire logic [23:0]            host_rdata_out,
  input wire logic                   host_rvalid_out,
  input wire logic                   gated_group_clock_out,
  input wire logic                   free_quarter_dot_clock_out,
  input wire vpp_pkg::vpp_level_type output_level_units_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  // shadow of the control word, built from bus writes only
  logic [23:0] ctl_q;
  logic [23:0] ctl_d;
  logic        sync_on;
  logic        ped_on;
  always_comb begin
    ctl_d = ctl_q;
    if (host_wr_in && host_addr_in == vpp_pkg::ADDR_CTL)
      ctl_d = host_addr_data_bus_in;
  end
  always_ff @(posedge clk_in) begin
    ctl_q <= srst_in ? vpp_pkg::CTL_RESET : ctl_d;
  end
  assign sync_on = ctl_q[vpp_pkg::CTL_SYNC_BIT];
  assign ped_on  = ctl_q[vpp_pkg::CTL_PED_BIT];
  // eight cycles cover the pin synchronisers plus the level pipeline
  sequence s_blank;
    (!active_in && $stable(ctl_q)) [*8];
  endsequence
  sequence s_sync_off;
    (!active_in && sync_n_in && $stable(ctl_q)) [*8];
  endsequence
  sequence s_sync_tip;
    (!active_in && !sync_n_in && $stable(ctl_q)) [*8];
  endsequence
  a_group_pulse: assert property (
    $fell(gated_group_clock_out) |=> gated_group_clock_out)
    else $error("group clock low too long");
  a_group_flyback: assert property (
    s_blank |-> gated_group_clock_out)
    else $error("group clock pulsed in flyback");
  a_quarter_rate: assert property (
    $changed(free_quarter_dot_clock_out) |=>
      $stable(free_quarter_dot_clock_out) ##1
      $changed(free_quarter_dot_clock_out))
    else $error("quarter clock off rate");
  a_read_answer: assert property (
    host_rd_in |=> host_rvalid_out)
    else $error("read not answered");
  a_answer_cause: assert property (
    host_rvalid_out |-> $past(host_rd_in))
    else $error("answer without read");
  a_unmapped_zero: assert property (
    host_rd_in && host_addr_in > 4'h6 |=> host_rdata_out == 24'h000000)
    else $error("unmapped read not zero");
  a_sync_pedestal: assert property (
    s_sync_off ##0 (sync_on && !ped_on) |->
      output_level_units_out == {3{vpp_pkg::SYNC_PED_UNITS}})
    else $error("sync offset wrong");
  a_sync_tip: assert property (
    s_sync_tip ##0 (sync_on && !ped_on) |->
      output_level_units_out == 27'h0000000)
    else $error("sync offset at sync tip");
  a_ped_blank: assert property (
    s_blank ##0 (ped_on && !sync_on) |->
      output_level_units_out == 27'h0000000)
    else $error("pedestal in blanking");
  a_level_range: assert property (
    output_level_units_out.red <= 9'h17F)
    else $error("level above full range");
endmodule
`default_nettype wire

// *** bench/vpp_pixel_source.sv ***
`default_nettype none
module vpp_pixel_source (
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  input  wire logic        direct_in,
  input  wire logic        group_clock_in,
  input  wire logic [31:0] word_in,
  output logic      [31:0] lanes_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // memory shifts a new word only once a group is taken
  // lanes pack {d, c, b, a}, pixel 0 in the low bits of lane a
  // a direct source presents a fresh pixel every dot
  always_ff @(posedge clk_in) begin
    if (srst_in) lanes_out <= ~word_in;
    else if (!group_clock_in || direct_in) lanes_out <= word_in;
  end
endmodule
`default_nettype wire

// *** bench/test_video_pixel_input_port.sv ***
`default_nettype none
module test_video_pixel_input_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0, srst_in = 1'b1, dot_en = 1'b1, direct = 1'b0;
  logic pll_en = 1'b1;
  logic active_in = 1'b0, sync_n_in = 1'b1, host_wr_in = 1'b0;
  logic host_rd_in = 1'b0, host_rvalid_out, gclk, qclk;
  logic [3:0] host_addr_in = 4'h0;
  logic [23:0] host_addr_data_bus_in = 24'h0, host_rdata_out;
  logic [31:0] word = 32'h0, lanes;
  logic [7:0] idx [8] = '{8'h00, 8'h01, 8'h02, 8'h03,
                          8'h11, 8'h22, 8'h33, 8'h44};
  vpp_pkg::vpp_level_type lvl;
  int mismatches = 0, checks = 0;
  always #50 clk_in = ~clk_in;
  vpp_video_pixel_input_port dut_u (.clk_in, .srst_in,
    .pll_dot_en_in(pll_en), .direct_dot_en_in(dot_en), .active_in,
    .sync_n_in, .pixel_lane_a_in(lanes[7:0]), .pixel_lane_b_in(lanes[15:8]),
    .pixel_lane_c_in(lanes[23:16]), .pixel_lane_d_in(lanes[31:24]),
    .host_wr_in, .host_rd_in, .host_addr_in, .host_addr_data_bus_in,
    .host_rdata_out, .host_rvalid_out, .gated_group_clock_out(gclk),
    .free_quarter_dot_clock_out(qclk), .output_level_units_out(lvl));
  vpp_pixel_source src_u (.clk_in, .srst_in, .direct_in(direct),
    .group_clock_in(gclk), .word_in(word), .lanes_out(lanes));
  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [26:0] e, g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [23:0] d);
    @(posedge clk_in);
    host_wr_in <= 1'b1;
    host_addr_in <= a;
    host_addr_data_bus_in <= d;
    @(posedge clk_in);
    host_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [23:0] e);
    @(posedge clk_in);
    host_rd_in <= 1'b1;
    host_addr_in <= a;
    @(posedge clk_in);
    host_rd_in <= 1'b0;
    #1 cmp("read data", {3'h0, e}, {3'h0, host_rdata_out});
    cmp("read valid", 27'h0000001, {26'h0, host_rvalid_out});
  endtask
  function automatic logic [23:0] pv(input logic [7:0] i);
    return {i, ~i, i ^ 8'h5A};
  endfunction
  // expected level: each 8-bit colour widened to its 9-bit channel
  function automatic logic [26:0] lv(input logic [23:0] e,
                                     input logic [8:0] add);
    return {9'(e[23:16]) + add, 9'(e[15:8]) + add, 9'(e[7:0]) + add};
  endfunction
  // lock onto the first pixel, then follow eight dots in display order
  task automatic show(input logic [23:0] c, input logic [31:0] w,
                      input logic [31:0] p, input logic [8:0] add);
    int k;
    int n;
    k = 0;
    n = 0;
    wr(vpp_pkg::ADDR_CTL, c);
    word <= w;
    active_in <= 1'b1;
    // at 1 bpp the leftover group and one stale group take 64 dots
    repeat (80) @(posedge clk_in);
    #1;
    while (lvl !== lv(pv(p[7:0]), add) && k < 40) begin
      @(posedge clk_in);
      #1 k++;
    end
    for (int i = 0; i < 8; i++) begin
      cmp("pixel", lv(pv(p[8 * (i % 4) +: 8]), add), lvl);
      @(posedge clk_in);
      #1;
    end
    // 32 dots hold exactly bpp group pulses
    repeat (32) begin
      @(posedge clk_in);
      #1 if (gclk === 1'b0) n++;
    end
    cmp("group pulses", 27'(1 << c[18:17]), 27'(n));
    @(posedge clk_in);
    active_in <= 1'b0;
    repeat (20) @(posedge clk_in);
  endtask
  initial begin
    #1_000_000 mismatches++;
    results();
  end
  initial begin
    repeat (4) @(posedge clk_in);
    srst_in <= 1'b0;
    rd(vpp_pkg::ADDR_CTL, 24'h000000);
    rd(vpp_pkg::ADDR_MASK, 24'h0000FF);
    rd(4'hF, 24'h000000);
    wr(vpp_pkg::ADDR_BOOT, 24'h000020);
    wr(vpp_pkg::ADDR_BOOT, 24'h000000);
    rd(vpp_pkg::ADDR_BOOT, 24'h000020);
    foreach (idx[i]) begin
      wr(vpp_pkg::ADDR_PAL_IDX, {16'h0, idx[i]});
      wr(vpp_pkg::ADDR_PAL_DATA, pv(idx[i]));
    end
    wr(vpp_pkg::ADDR_PAL_IDX, 24'h000022);
    rd(vpp_pkg::ADDR_PAL_DATA, pv(8'h22));
    // depth only changes while blanked
    show(24'h060000, 32'h44332211, 32'h44332211, 9'h0);
    show(24'h040000, 32'h21212121, 32'h02010201, 9'h0);
    show(24'h020000, 32'hE4E4E4E4, 32'h03020100, 9'h0);
    show(24'h000000, 32'h55555555, 32'h00010001, 9'h0);
    wr(vpp_pkg::ADDR_MASK, 24'h0000FE);
    show(24'h040000, 32'h21212121, 32'h02000200, 9'h0);
    wr(vpp_pkg::ADDR_MASK, 24'h0000FF);
    show(24'h061020, 32'h44332211, 32'h44332211, 9'h080);
    wr(vpp_pkg::ADDR_CTL, 24'h000020);
    repeat (20) @(posedge clk_in);
    #1 cmp("sync level", {3{9'h06C}}, lvl);
    @(posedge clk_in);
    sync_n_in <= 1'b0;
    repeat (20) @(posedge clk_in);
    #1 cmp("sync tip level", 27'h0, lvl);
    @(posedge clk_in);
    sync_n_in <= 1'b1;
    wr(vpp_pkg::ADDR_CTL, 24'h001000);
    repeat (20) @(posedge clk_in);
    #1 cmp("blank level", 27'h0, lvl);
    for (int i = 1; i < 4; i++) begin
      wr(vpp_pkg::ADDR_GAM_IDX, 24'(i * 16));
      wr(vpp_pkg::ADDR_GAM_DATA, 24'h010203 + 24'(i * 24'h101010));
    end
    wr(vpp_pkg::ADDR_MASK, 24'h000000);
    wr(vpp_pkg::ADDR_CTL, 24'h000001);
    direct <= 1'b1;
    pll_en <= 1'b0;
    word <= 32'h00302010;
    active_in <= 1'b1;
    repeat (20) @(posedge clk_in);
    #1 cmp("direct", {9'h011, 9'h022, 9'h033}, lvl);
    results();
  end
endmodule
bind vpp_video_pixel_input_port vpp_assertions chk_u (.clk_in, .srst_in,
  .active_in, .sync_n_in, .host_wr_in, .host_rd_in, .host_addr_in,
  .host_addr_data_bus_in, .host_rdata_out, .host_rvalid_out,
  .gated_group_clock_out, .free_quarter_dot_clock_out,
  .output_level_units_out);
`default_nettype wire
